// [core/swpc_ctrl.sv]
// Sleep and wake power mode controller with real-time counter and retention memory
// Notes on behaviour
// - Sleep from control write or USB standby
// - Wake on USB resume, pin or timer
// - Wake stimuli act only while asleep
// - Stimuli during sleep entry held pending
// - Pin level, counter match, enabled USB wake
// - 64-bit counter with programmable compare match
// - Awake counter adds one per main tick
// - Asleep counter may use slow oscillator
// - Slow ticks add programmed increment
// - Power-good loss in transition resets system
// - Asleep powers domain down; awake runs all
// - 128-byte retention memory readable after wake
// - Watchdog enabled only while awake
`timescale 1ns/1ns
`include "swpc_regs.svh"
module swpc_ctrl (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        usb_sleep_req,
    input  wire logic        usb_wake_req,
    input  wire logic        wake_pin,
    input  wire logic        slow_tick,
    input  wire logic        power_good,
    output logic             domain_on,
    output logic      [7:0]  sleep_cfg,
    output logic             sys_reset,
    output logic             wdog_en,
    output logic      [5:0]  state_out,
    output logic             irq
);
    swpc_pkg::swpc_state_t state_ff;
    swpc_pkg::swpc_state_t nxt_state;
    logic [`SWPC_C_W-1:0]     ctrl_ff;
    logic [`SWPC_EV_W-1:0]    ist_ff;
    logic [`SWPC_EV_W-1:0]    imask_ff;
    logic [63:0]              cnt_ff;
    logic [63:0]              cmp_ff;
    logic [31:0]              incr_ff;
    logic [`SWPC_SLPCFG_W-1:0] slpcfg_ff;
    logic [31:0]              ret_ff [`SWPC_RET_WORDS];
    logic [3:0]               step_ff;
    logic                     pend_ff;
    logic [31:0]              rdata_ff;
    logic                     rst_ff;
    logic                     pin_ev;
    logic                     rtc_ev;
    logic                     usb_ev;
    logic                     wake_any;
    logic                     step_done;
    logic                     in_trans;
    logic                     pg_fail;
    logic                     sleep_req;
    logic [`SWPC_EV_W-1:0]    ev_vec;
    logic [`SWPC_EV_W-1:0]    nxt_ist;
    logic [`SWPC_EV_W-1:0]    nxt_imask;
    logic                     irq_ff;
    logic                     domain_ff;

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] r);
        is_reg = (a == r);
    endfunction

    function automatic logic is_ret(input logic [7:0] a);
        is_ret = (a >= `SWPC_A_RET_BASE) && (a < `SWPC_A_RET_BASE + 8'(`SWPC_RET_WORDS));
    endfunction

    assign pin_ev    = ctrl_ff[`SWPC_C_PIN_EN] && (wake_pin == ctrl_ff[`SWPC_C_PIN_LVL]);
    assign rtc_ev    = ctrl_ff[`SWPC_C_RTC_EN] && (cnt_ff >= cmp_ff);
    assign usb_ev    = ctrl_ff[`SWPC_C_USB_EN] && usb_wake_req;
    assign wake_any  = pin_ev || rtc_ev || usb_ev || pend_ff;
    assign step_done = (step_ff == 4'(`SWPC_STEP_CYC - 1));
    assign in_trans  = (state_ff != swpc_pkg::ST_AWAKE) && (state_ff != swpc_pkg::ST_ASLEEP);
    assign pg_fail   = in_trans && !power_good;
    assign sleep_req = (wr && is_reg(addr, `SWPC_A_CTRL) && wdata[`SWPC_C_SLEEP])
                       || usb_sleep_req;
    assign ev_vec    = {pg_fail, usb_ev, rtc_ev, pin_ev};
    assign nxt_imask = (wr && is_reg(addr, `SWPC_A_IRQ_MASK)) ? wdata[`SWPC_EV_W-1:0]
                                                              : imask_ff;

    // Sticky event bits, set wins over clear
    always_comb begin
        nxt_ist = ist_ff | ev_vec;
        if (wr && is_reg(addr, `SWPC_A_IRQ_STAT)) begin
            nxt_ist = (ist_ff & ~wdata[`SWPC_EV_W-1:0]) | ev_vec;
        end
    end

    // Next state in fixed order
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            swpc_pkg::ST_AWAKE: begin
                if (sleep_req) begin
                    nxt_state = swpc_pkg::ST_SAVE;
                end
            end
            swpc_pkg::ST_SAVE: begin
                if (step_done) begin
                    nxt_state = swpc_pkg::ST_PWRDN;
                end
            end
            swpc_pkg::ST_PWRDN: begin
                if (step_done) begin
                    nxt_state = swpc_pkg::ST_ASLEEP;
                end
            end
            swpc_pkg::ST_ASLEEP: begin
                if (wake_any) begin
                    nxt_state = swpc_pkg::ST_PWRUP;
                end
            end
            swpc_pkg::ST_PWRUP: begin
                if (step_done) begin
                    nxt_state = swpc_pkg::ST_RESTORE;
                end
            end
            swpc_pkg::ST_RESTORE: begin
                if (step_done) begin
                    nxt_state = swpc_pkg::ST_AWAKE;
                end
            end
            default: nxt_state = swpc_pkg::ST_AWAKE;
        endcase
        if (pg_fail) begin
            nxt_state = swpc_pkg::ST_AWAKE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= swpc_pkg::ST_AWAKE;
        end else if (clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // Dwell counter for intermediate states
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step_ff <= 4'h0;
        end else if (clk_en) begin
            if (nxt_state != state_ff || !in_trans) begin
                step_ff <= 4'h0;
            end else begin
                step_ff <= step_ff + 4'h1;
            end
        end
    end

    // Wake stimulus captured during sleep entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= 1'b0;
        end else if (clk_en) begin
            if ((state_ff == swpc_pkg::ST_SAVE || state_ff == swpc_pkg::ST_PWRDN)
                && (pin_ev || rtc_ev || usb_ev)) begin
                pend_ff <= 1'b1;
            end else if (state_ff == swpc_pkg::ST_ASLEEP || state_ff == swpc_pkg::ST_AWAKE) begin
                pend_ff <= 1'b0;
            end
        end
    end

    // Real-time counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 64'h0000_0000_0000_0000;
        end else if (clk_en) begin
            if (wr && is_reg(addr, `SWPC_A_CNT_LO)) begin
                cnt_ff[31:0] <= wdata;
            end else if (wr && is_reg(addr, `SWPC_A_CNT_HI)) begin
                cnt_ff[63:32] <= wdata;
            end else if (state_ff == swpc_pkg::ST_ASLEEP && ctrl_ff[`SWPC_C_SLOW_EN]) begin
                if (slow_tick) begin
                    cnt_ff <= cnt_ff + {32'h0000_0000, incr_ff};
                end
            end else begin
                cnt_ff <= cnt_ff + 64'h0000_0000_0000_0001;
            end
        end
    end

    // Control, compare, increment, sleep configuration, mask
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff   <= '0;
            cmp_ff    <= 64'hFFFF_FFFF_FFFF_FFFF;
            incr_ff   <= `SWPC_INCR_RST;
            slpcfg_ff <= `SWPC_SLPCFG_RST;
            imask_ff  <= '0;
        end else if (clk_en && wr) begin
            if (is_reg(addr, `SWPC_A_CTRL)) begin
                ctrl_ff <= {wdata[`SWPC_C_W-1:1], 1'b0};
            end
            if (is_reg(addr, `SWPC_A_CMP_LO)) begin
                cmp_ff[31:0] <= wdata;
            end
            if (is_reg(addr, `SWPC_A_CMP_HI)) begin
                cmp_ff[63:32] <= wdata;
            end
            if (is_reg(addr, `SWPC_A_INCR)) begin
                incr_ff <= wdata;
            end
            if (is_reg(addr, `SWPC_A_SLPCFG)) begin
                slpcfg_ff <= wdata[`SWPC_SLPCFG_W-1:0];
            end
            if (is_reg(addr, `SWPC_A_IRQ_MASK)) begin
                imask_ff <= wdata[`SWPC_EV_W-1:0];
            end
        end
    end

    // Sticky event register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ist_ff <= '0;
        end else if (clk_en) begin
            ist_ff <= nxt_ist;
        end
    end

    // Interrupt level from the values the status and mask take at this edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else if (clk_en) begin
            irq_ff <= |(nxt_ist & nxt_imask);
        end
    end

    // Retention memory
    generate
        for (genvar i = 0; i < `SWPC_RET_WORDS; i++) begin : g_ret
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ret_ff[i] <= 32'h0000_0000;
                end else if (clk_en && wr && is_reg(addr, `SWPC_A_RET_BASE + 8'(i))) begin
                    ret_ff[i] <= wdata;
                end
            end
        end
    endgenerate

    // Read data, one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else if (clk_en) begin
            rdata_ff <= 32'h0000_0000;
            if (rd) begin
                if (is_ret(addr)) begin
                    rdata_ff <= ret_ff[addr[4:0]];
                end else begin
                    unique case (addr)
                        `SWPC_A_CTRL:     rdata_ff <= 32'(ctrl_ff);
                        `SWPC_A_STATUS:   rdata_ff <= 32'(state_ff);
                        `SWPC_A_IRQ_STAT: rdata_ff <= 32'(ist_ff);
                        `SWPC_A_IRQ_MASK: rdata_ff <= 32'(imask_ff);
                        `SWPC_A_CMP_LO:   rdata_ff <= cmp_ff[31:0];
                        `SWPC_A_CMP_HI:   rdata_ff <= cmp_ff[63:32];
                        `SWPC_A_CNT_LO:   rdata_ff <= cnt_ff[31:0];
                        `SWPC_A_CNT_HI:   rdata_ff <= cnt_ff[63:32];
                        `SWPC_A_INCR:     rdata_ff <= incr_ff;
                        `SWPC_A_SLPCFG:   rdata_ff <= 32'(slpcfg_ff);
                        default:          rdata_ff <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // System reset pulse on power-good loss during a transition
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_ff <= 1'b0;
        end else if (clk_en) begin
            rst_ff <= pg_fail;
        end
    end

    // Domain power, off only while asleep
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            domain_ff <= 1'b1;
        end else if (clk_en) begin
            domain_ff <= (nxt_state != swpc_pkg::ST_ASLEEP);
        end
    end

    assign rdata     = rdata_ff;
    assign sys_reset = rst_ff;
    assign state_out = state_ff;
    assign domain_on = domain_ff;
    assign wdog_en   = state_ff[0];
    assign sleep_cfg = slpcfg_ff;
    assign irq       = irq_ff;

    property p_sleep_start;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && state_ff == swpc_pkg::ST_AWAKE && sleep_req && power_good)
            |=> state_ff == swpc_pkg::ST_SAVE;
    endproperty
    a_sleep_start: assert property (p_sleep_start) else $error("sleep not started");

    property p_no_wake_awake;
        @(posedge clk) disable iff (!rst_n)
        (state_ff == swpc_pkg::ST_AWAKE && !sleep_req) |=> state_ff == swpc_pkg::ST_AWAKE;
    endproperty
    a_no_wake_awake: assert property (p_no_wake_awake) else $error("left awake w/o sleep");

    property p_wake;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && state_ff == swpc_pkg::ST_ASLEEP && (pin_ev || rtc_ev || usb_ev))
            |=> state_ff == swpc_pkg::ST_PWRUP;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not taken");

    property p_pending;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && state_ff == swpc_pkg::ST_PWRDN && (pin_ev || rtc_ev || usb_ev))
            |=> pend_ff;
    endproperty
    a_pending: assert property (p_pending) else $error("pending lost");

    property p_count_awake;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && state_ff == swpc_pkg::ST_AWAKE && !wr) |=> cnt_ff == $past(cnt_ff) + 64'h1;
    endproperty
    a_count_awake: assert property (p_count_awake) else $error("counter not +1");

    property p_pgood;
        @(posedge clk) disable iff (!rst_n)
        (clk_en && pg_fail) |=> sys_reset && state_ff == swpc_pkg::ST_AWAKE;
    endproperty
    a_pgood: assert property (p_pgood) else $error("no reset on power loss");

    property p_wdog;
        @(posedge clk) disable iff (!rst_n)
        wdog_en == (state_ff == swpc_pkg::ST_AWAKE) && domain_on == (state_ff != swpc_pkg::ST_ASLEEP);
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog/domain mismatch");

    sequence s_save;
        state_ff == swpc_pkg::ST_SAVE [*4];
    endsequence
    property p_order;
        @(posedge clk) disable iff (!rst_n || !clk_en || !power_good)
        $rose(state_ff == swpc_pkg::ST_SAVE) |-> s_save ##1 state_ff == swpc_pkg::ST_PWRDN;
    endproperty
    a_order: assert property (p_order) else $error("transition order broken");
endmodule

// [core/swpc_regs.svh]
// Register offsets, field positions, reset values and timing counts for the power controller
`ifndef SWPC_REGS_SVH
`define SWPC_REGS_SVH
`define SWPC_A_CTRL      8'h00
`define SWPC_A_STATUS    8'h01
`define SWPC_A_IRQ_STAT  8'h02
`define SWPC_A_IRQ_MASK  8'h03
`define SWPC_A_CMP_LO    8'h04
`define SWPC_A_CMP_HI    8'h05
`define SWPC_A_CNT_LO    8'h06
`define SWPC_A_CNT_HI    8'h07
`define SWPC_A_INCR      8'h08
`define SWPC_A_SLPCFG    8'h09
`define SWPC_A_RET_BASE  8'h80
`define SWPC_RET_WORDS   32
`define SWPC_C_SLEEP     0
`define SWPC_C_PIN_EN    1
`define SWPC_C_PIN_LVL   2
`define SWPC_C_RTC_EN    3
`define SWPC_C_USB_EN    4
`define SWPC_C_SLOW_EN   5
`define SWPC_C_W         6
`define SWPC_EV_PIN      0
`define SWPC_EV_RTC      1
`define SWPC_EV_USB      2
`define SWPC_EV_PGOOD    3
`define SWPC_EV_W        4
`define SWPC_SLPCFG_W    8
`define SWPC_SLPCFG_RST  8'h00
`define SWPC_INCR_RST    32'h0000_0140
`define SWPC_STEP_NS     400
`define SWPC_CLK_NS      100
`define SWPC_STEP_CYC    ((`SWPC_STEP_NS + `SWPC_CLK_NS - 1) / `SWPC_CLK_NS)
`endif

// [core/swpc_pkg.sv]
// Types of the sleep and wake power controller
package swpc_pkg;
    typedef enum logic [5:0] {
        ST_AWAKE  = 6'b00_0001,
        ST_SAVE   = 6'b00_0010,
        ST_PWRDN  = 6'b00_0100,
        ST_ASLEEP = 6'b00_1000,
        ST_PWRUP  = 6'b01_0000,
        ST_RESTORE= 6'b10_0000
    } swpc_state_t;
endpackage

// [verif/swpc_far_end.sv]
// Far-side model: USB block, wake pin and slow oscillator
`timescale 1ns/1ns
module swpc_far_end (
    input  wire logic clk,
    output logic      usb_sleep_req,
    output logic      usb_wake_req,
    output logic      wake_pin,
    output logic      slow_tick
);
    initial {usb_sleep_req, usb_wake_req, wake_pin, slow_tick} = 4'h0;
    // Standby request, one clock wide, issued whatever the controller state
    task automatic usb_standby();
        @(posedge clk) usb_sleep_req <= 1'h1;
        @(posedge clk) usb_sleep_req <= 1'h0;
        #1;
    endtask
    task automatic set_usb_wake(input logic v);
        @(posedge clk) usb_wake_req <= v;
        #1;
    endtask
    task automatic set_pin(input logic v);
        @(posedge clk) wake_pin <= v;
        #1;
    endtask
    // One slow oscillator tick, one clock wide
    task automatic tick();
        @(posedge clk) slow_tick <= 1'h1;
        @(posedge clk) slow_tick <= 1'h0;
        #1;
    endtask
endmodule

// [verif/swpc_ctrl_tb_top.sv]
// Testbench for the sleep and wake power controller
`timescale 1ns/1ns
`include "swpc_regs.svh"
module swpc_ctrl_tb_top;
    logic        clk, rst_n, clk_en, wr, rd, power_good, irq;
    logic        usb_sleep_req, usb_wake_req, wake_pin, slow_tick;
    logic        domain_on, sys_reset, wdog_en;
    logic [7:0]  addr, sleep_cfg;
    logic [31:0] wdata, rdata, v, v1;
    logic [5:0]  state_out;
    int          n_errors, cmp_count, n;

    swpc_ctrl swpc_ctrl_i (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .usb_sleep_req(usb_sleep_req),
        .usb_wake_req(usb_wake_req), .wake_pin(wake_pin), .slow_tick(slow_tick),
        .power_good(power_good), .domain_on(domain_on), .sleep_cfg(sleep_cfg),
        .sys_reset(sys_reset), .wdog_en(wdog_en), .state_out(state_out), .irq(irq));
    swpc_far_end swpc_far_end_i (.clk(clk), .usb_sleep_req(usb_sleep_req),
        .usb_wake_req(usb_wake_req), .wake_pin(wake_pin), .slow_tick(slow_tick));

    always #50 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        d = rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd_reg(a, d);
        chk(d, exp);
    endtask
    // Bounded wait for a state; cyc gives the cycles spent waiting
    task automatic wait_st(input logic [5:0] s, output int cyc);
        cyc = 0;
        while (state_out !== s && cyc < 2000) begin
            @(posedge clk);
            #1;
            cyc++;
        end
        chk(state_out, s);
    endtask
    task automatic go_sleep(input logic [31:0] ctrl);
        wr_reg(`SWPC_A_CTRL, ctrl | 32'h0000_0001);
        chk(state_out, swpc_pkg::ST_SAVE);
        chk(wdog_en, 1'h0);
        wait_st(swpc_pkg::ST_PWRDN, n);
        chk(n, 32'h0000_0004);
        wait_st(swpc_pkg::ST_ASLEEP, n);
        chk(n, 32'h0000_0004);
    endtask
    task automatic wake_seq();
        wait_st(swpc_pkg::ST_PWRUP, n);
        wait_st(swpc_pkg::ST_RESTORE, n);
        chk(n, 32'h0000_0004);
        wait_st(swpc_pkg::ST_AWAKE, n);
        chk(n, 32'h0000_0004);
        chk({wdog_en, domain_on}, 2'h3);
    endtask
    task automatic end_sim();
        if (n_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        #2_000_000;
        n_errors++;
        end_sim();
    end

    initial begin
        {clk, rst_n, wr, rd, addr, wdata, n_errors, cmp_count} = '0;
        {clk_en, power_good} = 2'h3;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        #1;
        chk({state_out, wdog_en, domain_on}, {swpc_pkg::ST_AWAKE, 2'h3});
        rd_chk(`SWPC_A_STATUS, 32'h0000_0001);
        rd_chk(`SWPC_A_INCR, 32'h0000_0140);
        rd_chk(`SWPC_A_CTRL, 32'h0000_0000);
        rd_chk(8'h0a, 32'h0000_0000);
        // Clock enable low freezes the counter
        rd_reg(`SWPC_A_CNT_LO, v1);
        @(posedge clk) clk_en <= 1'h0;
        repeat (5) @(posedge clk);
        clk_en <= 1'h1;
        rd_chk(`SWPC_A_CNT_LO, v1 + 32'h0000_0003);
        wr_reg(`SWPC_A_SLPCFG, 32'h0000_005a);
        chk(sleep_cfg, 8'h5a);
        wr_reg(`SWPC_A_RET_BASE, 32'hcafe_0001);
        wr_reg(8'h9f, 32'h1234_5678);
        wr_reg(8'ha0, 32'hffff_ffff);
        rd_chk(8'ha0, 32'h0000_0000);
        // Wake stimulus while awake: flags only, no transition
        wr_reg(`SWPC_A_IRQ_MASK, 32'h0000_0001);
        wr_reg(`SWPC_A_CTRL, 32'h0000_0006);
        swpc_far_end_i.set_pin(1'h1);
        repeat (10) @(posedge clk);
        #1;
        chk({state_out, irq}, {swpc_pkg::ST_AWAKE, 1'h1});
        wr_reg(`SWPC_A_IRQ_MASK, 32'h0000_0000);
        chk(irq, 1'h0);
        wr_reg(`SWPC_A_IRQ_MASK, 32'h0000_0001);
        swpc_far_end_i.set_pin(1'h0);
        repeat (4) @(posedge clk);
        wr_reg(`SWPC_A_IRQ_STAT, 32'h0000_000f);
        chk(irq, 1'h0);
        rd_chk(`SWPC_A_IRQ_STAT, 32'h0000_0000);
        // Sleep on write, slow counting, wake on pin deassertion
        swpc_far_end_i.set_pin(1'h1);
        wr_reg(`SWPC_A_INCR, 32'h0000_0010);
        go_sleep(32'h0000_0022);
        chk({domain_on, wdog_en}, 2'h0);
        rd_reg(`SWPC_A_CNT_LO, v1);
        repeat (5) @(posedge clk);
        rd_chk(`SWPC_A_CNT_LO, v1);
        swpc_far_end_i.tick();
        rd_chk(`SWPC_A_CNT_LO, v1 + 32'h0000_0010);
        swpc_far_end_i.set_pin(1'h0);
        wake_seq();
        rd_chk(`SWPC_A_RET_BASE, 32'hcafe_0001);
        rd_chk(8'h9f, 32'h1234_5678);
        // USB standby, then a resume during entry that stays pending
        wr_reg(`SWPC_A_CTRL, 32'h0000_0010);
        swpc_far_end_i.usb_standby();
        chk(state_out, swpc_pkg::ST_SAVE);
        swpc_far_end_i.set_usb_wake(1'h1);
        swpc_far_end_i.set_usb_wake(1'h0);
        wait_st(swpc_pkg::ST_ASLEEP, n);
        wait_st(swpc_pkg::ST_PWRUP, n);
        chk(n, 32'h0000_0001);
        wake_seq();
        // Counter rate when awake, then wake on counter match
        wr_reg(`SWPC_A_CMP_HI, 32'h0000_0000);
        wr_reg(`SWPC_A_CNT_HI, 32'h0000_0000);
        wr_reg(`SWPC_A_CNT_LO, 32'h0000_0000);
        wr_reg(`SWPC_A_CMP_LO, 32'h0000_012c);
        rd_reg(`SWPC_A_CNT_LO, v1);
        rd_chk(`SWPC_A_CNT_LO, v1 + 32'h0000_0002);
        go_sleep(32'h0000_0008);
        wait_st(swpc_pkg::ST_PWRUP, n);
        chk({31'h0, n > 250 && n < 300}, 32'h0000_0001);
        wake_seq();
        wr_reg(`SWPC_A_CMP_HI, 32'hffff_ffff);
        rd_reg(`SWPC_A_IRQ_STAT, v);
        chk(v & 32'h0000_0002, 32'h0000_0002);
        // Supply failure during sleep entry
        wr_reg(`SWPC_A_CTRL, 32'h0000_0001);
        chk(state_out, swpc_pkg::ST_SAVE);
        @(posedge clk) power_good <= 1'h0;
        @(posedge clk);
        #1;
        chk({state_out, sys_reset}, {swpc_pkg::ST_AWAKE, 1'h1});
        @(posedge clk) power_good <= 1'h1;
        #1;
        chk(sys_reset, 1'h0);
        rd_reg(`SWPC_A_IRQ_STAT, v);
        chk(v & 32'h0000_0008, 32'h0000_0008);
        end_sim();
    end
endmodule
